/* logic/tpcm_pkg.sv */
// constants shared by the timer pulse and capture block
package tpcm_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_a_addr = 8'h00;
  localparam logic [7:0] ctrl_b_addr = 8'h04;
  localparam logic [7:0] cmp_a_addr = 8'h08;
  localparam logic [7:0] cmp_b_addr = 8'h0c;
  localparam logic [7:0] period_addr = 8'h10;
  localparam logic [7:0] flags_addr = 8'h14;
  localparam logic [7:0] count_addr = 8'h18;
  // control field positions
  localparam int mode_lo_bit = 0;
  localparam int pin_ctrl_lo_bit = 2;
  localparam int init_level_bit = 4;
  localparam int polarity_bit = 5;
  localparam int pwm_align_lo_bit = 6;
  localparam int clear_select_bit = 8;
  localparam int run_bit = 9;
  // flag positions
  localparam int flag_a_bit = 0;
  localparam int flag_b_bit = 1;
  localparam int flag_p_bit = 2;
  // widths
  localparam int cmp_w = 10;
  localparam int cnt_w = 11;
  localparam int period_w = 3;
  // mode field encodings
  localparam logic [1:0] mode_compare = 2'h0;
  localparam logic [1:0] mode_capture = 2'h1;
  localparam logic [1:0] mode_pwm = 2'h2;
  localparam logic [1:0] mode_timer = 2'h3;
  localparam logic [1:0] align_centre = 2'h3;
  // pin control encodings
  localparam logic [1:0] pin_off = 2'h0;
  localparam logic [1:0] pin_low = 2'h1;
  localparam logic [1:0] pin_high = 2'h2;
  localparam logic [1:0] pin_toggle = 2'h3;
  localparam logic [1:0] pin_pwm = 2'h2;
  localparam logic [1:0] pin_single = 2'h3;
  localparam logic [1:0] edge_rise = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;
  localparam logic [1:0] edge_both = 2'h2;
  // period comparator step and full count
  localparam int period_shift = 7;
  localparam logic [10:0] period_full = 11'h400;
  // ahb encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
endpackage

/* logic/tpcm_edge.sv */
// two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ns
module tpcm_edge (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // asynchronous pin
  input wire logic pin_async,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first stage only feeds the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edges are seen in the same cycle as the synchronised level changes
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule

/* logic/tpcm_ahb.sv */
// ahb-lite slave front end: zero wait states, okay answers only
`timescale 1ns/1ns
module tpcm_ahb (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register file side
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data
);
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic take;
  logic word_ok;

  // only whole aligned words are acted on; others complete with no effect
  assign word_ok = (hsize == tpcm_pkg::hsize_word) && (haddr[1:0] == 2'h0);
  assign take = hsel && hready && htrans[1] && word_ok;
  assign rd_addr = haddr[7:0];

  // address phase: remember write target, sample read data for the data phase
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      if (hready) begin
        wr_pend_reg <= take && hwrite;
        wr_addr_reg <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata_reg <= rd_data;
      end
    end
  end

  // data phase write strobe uses hwdata as it stands now
  assign wr_en = wr_pend_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = hwdata;
  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

/* logic/tpcm_top.sv */
// enhanced timer module: compare, pwm, single pulse and capture with ahb-lite registers
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
module tpcm_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // timer pins a and b, two-way
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe,
  input wire logic timer_pin_b_in,
  output logic timer_pin_b_out,
  output logic timer_pin_b_oe,
  // external clock pin used as single pulse trigger
  input wire logic external_timer_clock_pin
);
  // bus front end wires
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  // widths from the package, declared before any signal that uses them
  localparam int cmp_w_c = tpcm_pkg::cmp_w;
  localparam int cnt_w_c = tpcm_pkg::cnt_w;
  localparam int period_w_c = tpcm_pkg::period_w;

  // control registers, one entry per channel where fields repeat
  logic [1:0] mode_reg [2];
  logic [1:0] pin_ctrl_reg [2];
  logic init_level_reg [2];
  logic polarity_reg [2];
  logic [cmp_w_c-1:0] cmp_reg [2];
  logic [1:0] pwm_align_reg;
  logic counter_clear_select_reg;
  logic counter_run_bit_reg;
  logic counter_run_bit_next;
  logic run_prev_reg;
  logic [2:0] period_compare_value_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;

  // counter state
  logic [cnt_w_c-1:0] cnt_reg;
  logic [cnt_w_c-1:0] cnt_next;
  logic count_up_reg;
  logic count_up_next;

  // synchronised pins
  logic pin_rise [2];
  logic pin_fall [2];
  logic ext_rise;

  tpcm_ahb u_ahb (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // pins are always sampled, whatever the output enable says
  tpcm_edge u_edge_a (
    .clock(clock),
    .rst(rst),
    .pin_async(timer_pin_a_in),
    .level(),
    .rise(pin_rise[0]),
    .fall(pin_fall[0])
  );

  tpcm_edge u_edge_b (
    .clock(clock),
    .rst(rst),
    .pin_async(timer_pin_b_in),
    .level(),
    .rise(pin_rise[1]),
    .fall(pin_fall[1])
  );

  tpcm_edge u_edge_ext (
    .clock(clock),
    .rst(rst),
    .pin_async(external_timer_clock_pin),
    .level(),
    .rise(ext_rise),
    .fall()
  );

  // register write decode
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_cmp [2];
  logic wr_period;
  logic wr_flags;
  assign wr_ctrl_a = wr_en && (wr_addr == tpcm_pkg::ctrl_a_addr);
  assign wr_ctrl_b = wr_en && (wr_addr == tpcm_pkg::ctrl_b_addr);
  assign wr_cmp[0] = wr_en && (wr_addr == tpcm_pkg::cmp_a_addr);
  assign wr_cmp[1] = wr_en && (wr_addr == tpcm_pkg::cmp_b_addr);
  assign wr_period = wr_en && (wr_addr == tpcm_pkg::period_addr);
  assign wr_flags = wr_en && (wr_addr == tpcm_pkg::flags_addr);

  // operating mode follows channel a fields, single pulse those of both channels; software sets both alike
  logic run_rise;
  logic running;
  logic is_capture;
  logic is_pwm;
  logic is_single;
  logic is_centre;
  logic clear_on_a;
  assign run_rise = counter_run_bit_reg && !run_prev_reg;
  assign running = counter_run_bit_reg;
  assign is_capture = (mode_reg[0] == tpcm_pkg::mode_capture);
  assign is_single = (mode_reg[0] == tpcm_pkg::mode_pwm) && (mode_reg[1] == tpcm_pkg::mode_pwm)
                     && (pin_ctrl_reg[0] == tpcm_pkg::pin_single)
                     && (pin_ctrl_reg[1] == tpcm_pkg::pin_single);
  assign is_pwm = (mode_reg[0] == tpcm_pkg::mode_pwm) && !is_single;
  assign is_centre = is_pwm && (pwm_align_reg == tpcm_pkg::align_centre);
  assign clear_on_a = counter_clear_select_reg && !is_capture && !is_single;

  // period top: 128-count steps, code 0 gives the full 1024
  logic [cnt_w_c-1:0] period_top;
  logic [cnt_w_c-1:0] top_val;
  logic wrap_hit;
  assign period_top = (period_compare_value_reg == 3'h0) ? tpcm_pkg::period_full
                      : cnt_w_c'({period_compare_value_reg, 7'h00});
  assign top_val = clear_on_a ? {1'b0, cmp_reg[0]} : period_top;
  assign wrap_hit = running && (cnt_reg == top_val - 11'h001);

  // comparator matches; with clear on a in edge alignment the period end is the a match
  logic match [2];
  logic p_evt;
  assign match[0] = running && (clear_on_a && !is_centre ? wrap_hit : (cnt_reg == {1'b0, cmp_reg[0]}));
  assign match[1] = running && (cnt_reg == {1'b0, cmp_reg[1]});
  assign p_evt = is_centre ? (running && !count_up_reg && (cnt_reg == 11'h001))
                 : (!is_single && !clear_on_a && wrap_hit);

  // capture edge select per channel
  logic cap_evt [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cap
      logic sel_rise;
      logic sel_fall;
      assign sel_rise = (pin_ctrl_reg[g] == tpcm_pkg::edge_rise) || (pin_ctrl_reg[g] == tpcm_pkg::edge_both);
      assign sel_fall = (pin_ctrl_reg[g] == tpcm_pkg::edge_fall) || (pin_ctrl_reg[g] == tpcm_pkg::edge_both);
      assign cap_evt[g] = is_capture && running && ((sel_rise && pin_rise[g]) || (sel_fall && pin_fall[g]));
    end
  endgenerate

  // counter: zeroed on run rise, held while stopped
  always_comb begin
    cnt_next = cnt_reg;
    count_up_next = count_up_reg;
    if (run_rise) begin
      cnt_next = '0;
      count_up_next = 1'b1;
    end else if (!running) begin
      cnt_next = cnt_reg;
    end else if (is_single) begin
      cnt_next = cnt_reg + 11'h001;
    end else if (is_centre) begin
      if (count_up_reg) begin
        if (cnt_reg >= top_val) begin
          count_up_next = 1'b0;
          cnt_next = cnt_reg - 11'h001;
        end else begin
          cnt_next = cnt_reg + 11'h001;
        end
      end else if (cnt_reg == 11'h000) begin
        count_up_next = 1'b1;
        cnt_next = 11'h001;
      end else begin
        cnt_next = cnt_reg - 11'h001;
      end
    end else if (wrap_hit) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
      count_up_reg <= 1'b1;
      run_prev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      count_up_reg <= count_up_next;
      run_prev_reg <= counter_run_bit_reg;
    end
  end

  // run bit: software write, an a match in single pulse clears it, external edge sets it last so the set wins
  always_comb begin
    counter_run_bit_next = counter_run_bit_reg;
    if (wr_ctrl_a) begin
      counter_run_bit_next = wr_data[tpcm_pkg::run_bit];
    end
    if (is_single && match[0]) begin
      counter_run_bit_next = 1'b0;
    end
    if (is_single && ext_rise) begin
      counter_run_bit_next = 1'b1;
    end
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  logic [2:0] flag_evt;
  assign flag_evt[tpcm_pkg::flag_a_bit] = is_capture ? cap_evt[0] : match[0];
  assign flag_evt[tpcm_pkg::flag_b_bit] = is_capture ? cap_evt[1] : match[1];
  assign flag_evt[tpcm_pkg::flag_p_bit] = p_evt;
  assign flags_next = (flags_reg & ~(wr_flags ? wr_data[2:0] : 3'h0)) | flag_evt;

  // control and flag registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pwm_align_reg <= 2'h0;
      counter_clear_select_reg <= 1'b0;
      counter_run_bit_reg <= 1'b0;
      period_compare_value_reg <= 3'h0;
      flags_reg <= 3'h0;
    end else begin
      counter_run_bit_reg <= counter_run_bit_next;
      flags_reg <= flags_next;
      if (wr_ctrl_a) begin
        pwm_align_reg <= wr_data[tpcm_pkg::pwm_align_lo_bit +: 2];
        counter_clear_select_reg <= wr_data[tpcm_pkg::clear_select_bit];
      end
      if (wr_period) begin
        period_compare_value_reg <= wr_data[period_w_c-1:0];
      end
    end
  end

  // per channel: fields, compare register with capture, and pin output
  logic pin_out [2];
  logic pin_oe [2];
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic wr_ctrl;
      logic cmp_state_reg;
      logic pulse_reg;
      logic pwm_active;
      logic level;
      assign wr_ctrl = (g == 0) ? wr_ctrl_a : wr_ctrl_b;

      // capture has priority over a software write in the same cycle
      always_ff @(posedge clock) begin
        if (rst) begin
          mode_reg[g] <= 2'h0;
          pin_ctrl_reg[g] <= 2'h0;
          init_level_reg[g] <= 1'b0;
          polarity_reg[g] <= 1'b0;
          cmp_reg[g] <= '0;
        end else begin
          if (wr_ctrl) begin
            mode_reg[g] <= wr_data[tpcm_pkg::mode_lo_bit +: 2];
            pin_ctrl_reg[g] <= wr_data[tpcm_pkg::pin_ctrl_lo_bit +: 2];
            init_level_reg[g] <= wr_data[tpcm_pkg::init_level_bit];
            polarity_reg[g] <= wr_data[tpcm_pkg::polarity_bit];
          end
          if (cap_evt[g]) begin
            cmp_reg[g] <= cnt_reg[cmp_w_c-1:0];
          end else if (wr_cmp[g]) begin
            cmp_reg[g] <= wr_data[cmp_w_c-1:0];
          end
        end
      end

      // compare-output pin state and single pulse state
      always_ff @(posedge clock) begin
        if (rst) begin
          cmp_state_reg <= 1'b0;
          pulse_reg <= 1'b0;
        end else begin
          if (run_rise) begin
            cmp_state_reg <= init_level_reg[g];
          end else if (match[g]) begin
            case (pin_ctrl_reg[g])
              tpcm_pkg::pin_low: cmp_state_reg <= 1'b0;
              tpcm_pkg::pin_high: cmp_state_reg <= 1'b1;
              tpcm_pkg::pin_toggle: cmp_state_reg <= ~cmp_state_reg;
              default: cmp_state_reg <= cmp_state_reg;
            endcase
          end
          if (!counter_run_bit_reg) begin
            pulse_reg <= 1'b0;
          end else if ((g == 0) ? run_rise : match[1]) begin
            pulse_reg <= 1'b1;
          end
        end
      end

      // pwm duty is computed every cycle whatever the pin control says
      assign pwm_active = running && (cnt_reg < {1'b0, cmp_reg[g]});

      // output level; polarity and initial level ignored in capture
      always_comb begin
        level = 1'b0;
        pin_oe[g] = 1'b0;
        case (mode_reg[g])
          tpcm_pkg::mode_compare: begin
            level = cmp_state_reg;
            pin_oe[g] = 1'b1;
          end
          tpcm_pkg::mode_pwm: begin
            pin_oe[g] = !(g == 0 && clear_on_a);
            if (is_single) begin
              level = pulse_reg ? init_level_reg[g] : ~init_level_reg[g];
            end else if (pin_ctrl_reg[g] == tpcm_pkg::pin_pwm) begin
              level = pwm_active ? init_level_reg[g] : ~init_level_reg[g];
            end else begin
              level = (pin_ctrl_reg[g] == tpcm_pkg::pin_low) ? init_level_reg[g] : ~init_level_reg[g];
            end
          end
          default: begin
            level = 1'b0;
            pin_oe[g] = 1'b0;
          end
        endcase
      end
      assign pin_out[g] = (mode_reg[g] == tpcm_pkg::mode_capture) ? 1'b0 : (level ^ polarity_reg[g]);
    end
  endgenerate

  assign timer_pin_a_out = pin_out[0];
  assign timer_pin_a_oe = pin_oe[0];
  assign timer_pin_b_out = pin_out[1];
  assign timer_pin_b_oe = pin_oe[1];

  // read mux; unmapped offsets read zero
  logic [31:0] ctrl_a_word;
  logic [31:0] ctrl_b_word;
  assign ctrl_a_word = {22'h000000, counter_run_bit_reg, counter_clear_select_reg, pwm_align_reg,
                        polarity_reg[0], init_level_reg[0], pin_ctrl_reg[0], mode_reg[0]};
  assign ctrl_b_word = {26'h0000000, polarity_reg[1], init_level_reg[1], pin_ctrl_reg[1], mode_reg[1]};
  assign rd_data = (rd_addr == tpcm_pkg::ctrl_a_addr) ? ctrl_a_word
                 : (rd_addr == tpcm_pkg::ctrl_b_addr) ? ctrl_b_word
                 : (rd_addr == tpcm_pkg::cmp_a_addr) ? {22'h000000, cmp_reg[0]}
                 : (rd_addr == tpcm_pkg::cmp_b_addr) ? {22'h000000, cmp_reg[1]}
                 : (rd_addr == tpcm_pkg::period_addr) ? {29'h00000000, period_compare_value_reg}
                 : (rd_addr == tpcm_pkg::flags_addr) ? {29'h00000000, flags_reg}
                 : (rd_addr == tpcm_pkg::count_addr) ? {21'h000000, cnt_reg}
                 : 32'h00000000;
endmodule

/* verification/tpcm_pin_model.sv */
// far side of the timer pins: external sources and the trigger pin
`timescale 1ns/1ns
module tpcm_pin_model (
  // drives from the block
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // levels applied from outside
  input wire logic a_drv,
  input wire logic b_drv,
  input wire logic trig,
  // resolved wires
  output logic a_pin,
  output logic b_pin,
  output logic ext_pin
);
  // the block's own drive wins, so its transitions also reach the inputs
  assign a_pin = a_oe ? a_out : a_drv;
  assign b_pin = b_oe ? b_out : b_drv;
  assign ext_pin = trig;
endmodule

/* verification/tpcm_monitor.sv */
// assertions on the timer block's bus and pin ports
`timescale 1ns/1ns
module tpcm_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic timer_pin_a_out,
  input wire logic timer_pin_a_oe,
  input wire logic timer_pin_b_out,
  input wire logic timer_pin_b_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // shadow of control writes, so pin checks know mode and levels
  logic wr_pend_reg, rd_pend_reg, clr_a_reg;
  logic [7:0] wr_adr_reg;
  logic [5:0] ctl_a_reg, ctl_b_reg;
  wire take = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[1:0] == 2'h0;
  wire both_cap = ctl_a_reg[1:0] == tpcm_pkg::mode_capture && ctl_b_reg[1:0] == tpcm_pkg::mode_capture;
  wire both_pwm = ctl_a_reg[1:0] == tpcm_pkg::mode_pwm && ctl_b_reg[1:0] == tpcm_pkg::mode_pwm;
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      clr_a_reg <= 1'b0;
      wr_adr_reg <= 8'h00;
      ctl_a_reg <= 6'h00;
      ctl_b_reg <= 6'h00;
    end else begin
      wr_pend_reg <= take && hwrite;
      rd_pend_reg <= take && !hwrite;
      wr_adr_reg <= haddr[7:0];
      if (wr_pend_reg && wr_adr_reg == tpcm_pkg::ctrl_a_addr) begin
        ctl_a_reg <= hwdata[5:0];
        clr_a_reg <= hwdata[8];
      end
      if (wr_pend_reg && wr_adr_reg == tpcm_pkg::ctrl_b_addr) begin
        ctl_b_reg <= hwdata[5:0];
      end
    end
  end
  ready_high_a: assert property (hreadyout) else $error("hreadyout dropped");
  okay_resp_a: assert property (!hresp) else $error("error response");
  rdata_hold_a: assert property (!rd_pend_reg |-> $stable(hrdata)) else $error("hrdata moved without read");
  reset_clear_a: assert property ($fell(rst) |-> hrdata == 32'h0 && timer_pin_a_oe && !timer_pin_a_out)
    else $error("bad state after reset");
  capa_quiet_a: assert property (both_cap |-> !timer_pin_a_oe && !timer_pin_a_out)
    else $error("pin a driven in capture");
  capb_quiet_a: assert property (both_cap |-> !timer_pin_b_oe && !timer_pin_b_out)
    else $error("pin b driven in capture");
  force_act_a: assert property (both_pwm && !clr_a_reg && ctl_a_reg[3:2] == 2'h1
    |-> timer_pin_a_out == (ctl_a_reg[4] ^ ctl_a_reg[5])) else $error("pin a not forced active");
  force_idle_a: assert property (both_pwm && ctl_b_reg[3:2] == 2'h0
    |-> timer_pin_b_out == !(ctl_b_reg[4] ^ ctl_b_reg[5])) else $error("pin b not forced idle");
endmodule
bind tpcm_top tpcm_monitor u_mon (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe(timer_pin_a_oe),
  .timer_pin_b_out(timer_pin_b_out), .timer_pin_b_oe(timer_pin_b_oe));

/* verification/timer_pulse_capture_modes_tb.sv */
// testbench for the timer pulse and capture block
`timescale 1ns/1ns
module timer_pulse_capture_modes_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hwrite = 1'b0, a_drv = 1'b0, b_drv = 1'b0, trig = 1'b0, dn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, cnt;
  wire hready, hresp, pa_o, pa_oe, pb_o, pb_oe, pa_i, pb_i, ext;
  wire [31:0] hrdata;
  int err_total = 0, samples_checked = 0, cyc = 0;
  tpcm_top u_dut (.clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .timer_pin_a_in(pa_i), .timer_pin_a_out(pa_o), .timer_pin_a_oe(pa_oe), .timer_pin_b_in(pb_i),
    .timer_pin_b_out(pb_o), .timer_pin_b_oe(pb_oe), .external_timer_clock_pin(ext));
  tpcm_pin_model u_pins (.a_out(pa_o), .a_oe(pa_oe), .b_out(pb_o), .b_oe(pb_oe), .a_drv(a_drv),
    .b_drv(b_drv), .trig(trig), .a_pin(pa_i), .b_pin(pb_i), .ext_pin(ext));
  // 10 mhz clock
  initial forever #50 clock = ~clock;
  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one single ahb transfer; entered just after a rising edge
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
    htrans <= tpcm_pkg::htrans_nonseq;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] m, logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge clock);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] m, p, logic il, po, logic [1:0] al, logic cs, rn);
    return {22'h0, rn, cs, al, po, il, p, m};
  endfunction
  // main sequence
  initial begin
    wt(8);
    rst <= 1'b0;
    wt(1);
    rdchk(tpcm_pkg::ctrl_a_addr, 32'hffffffff, 32'h0);
    wr(8'h40, 32'h1234);
    rdchk(8'h40, 32'hffffffff, 32'h0);
    // capture edge codes on pin a, with clear select, level and polarity set to no effect
    wr(tpcm_pkg::ctrl_b_addr, ctl(tpcm_pkg::mode_capture, 2'h3, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0));
    for (int c = 0; c < 4; c++) begin
      wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_capture, c[1:0], 1'b1, 1'b1, 2'h0, 1'b1, 1'b1));
      a_drv <= 1'b1;
      wt(6);
      rdchk(tpcm_pkg::flags_addr, 32'h1, {31'h0, c == 0 || c == 2});
      wr(tpcm_pkg::flags_addr, 32'h7);
      a_drv <= 1'b0;
      wt(6);
      rdchk(tpcm_pkg::flags_addr, 32'h1, {31'h0, c == 1 || c == 2});
      wr(tpcm_pkg::flags_addr, 32'h7);
    end
    // captured value on pin b lies just below the live count
    wr(tpcm_pkg::cmp_b_addr, 32'h3ff);
    wr(tpcm_pkg::ctrl_b_addr, ctl(tpcm_pkg::mode_capture, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    b_drv <= 1'b1;
    wt(6);
    bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
    cnt = rd;
    bus(tpcm_pkg::cmp_b_addr, 1'b0, 32'h0);
    chk({31'h0, cnt - rd < 32'd16}, 32'h1);
    rdchk(tpcm_pkg::flags_addr, 32'h2, 32'h2);
    // period bound: restart the count, then 128 counts wrap it
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_capture, 2'h3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    wr(tpcm_pkg::period_addr, 32'h1);
    wr(tpcm_pkg::flags_addr, 32'h7);
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_capture, 2'h3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    wt(300);
    rdchk(tpcm_pkg::flags_addr, 32'h4, 32'h4);
    bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
    chk({31'h0, rd < 32'd128}, 32'h1);
    // single pulse: a from run, b from compare b, both end on compare a
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_capture, 2'h3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0));
    wr(tpcm_pkg::cmp_a_addr, 32'd40);
    wr(tpcm_pkg::cmp_b_addr, 32'd10);
    wr(tpcm_pkg::flags_addr, 32'h7);
    wr(tpcm_pkg::ctrl_b_addr, ctl(tpcm_pkg::mode_pwm, 2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0));
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1));
    wt(2);
    chk({30'h0, pa_o, pb_o}, 32'h2);
    wt(15);
    chk({31'h0, pb_o}, 32'h1);
    wt(40);
    chk({30'h0, pa_o, pb_o}, 32'h0);
    rdchk(tpcm_pkg::ctrl_a_addr, 32'h200, 32'h0);
    rdchk(tpcm_pkg::flags_addr, 32'h3, 32'h3);
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1));
    // a read right after the write would still see the held count, the restart lands one cycle later
    wt(2);
    bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
    chk({31'h0, rd < 32'd8}, 32'h1);
    wt(60);
    // trigger pin sets the run bit by itself
    trig <= 1'b1;
    wt(6);
    trig <= 1'b0;
    rdchk(tpcm_pkg::ctrl_a_addr, 32'h200, 32'h200);
    chk({31'h0, pa_o}, 32'h1);
    wt(60);
    // pwm with forced pins: generation goes on underneath
    wr(tpcm_pkg::ctrl_b_addr, ctl(tpcm_pkg::mode_pwm, 2'h1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0));
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h1, 1'b1, 1'b0, 2'h0, 1'b0, 1'b1));
    wt(2);
    chk({30'h0, pa_o, pb_o}, 32'h2);
    bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
    cnt = rd;
    wt(20);
    bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
    chk({31'h0, rd != cnt}, 32'h1);
    wr(tpcm_pkg::ctrl_b_addr, ctl(tpcm_pkg::mode_pwm, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0));
    wt(2);
    chk({31'h0, pb_o}, 32'h1);
    // centre alignment: period request on the way down
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h1, 1'b1, 1'b0, tpcm_pkg::align_centre, 1'b0, 1'b1));
    wr(tpcm_pkg::flags_addr, 32'h7);
    wt(600);
    rdchk(tpcm_pkg::flags_addr, 32'h4, 32'h4);
    // back-to-back reads are two cycles apart: only a down-count falls by exactly two
    for (int i = 0; i < 80; i++) begin
      cnt = rd;
      bus(tpcm_pkg::count_addr, 1'b0, 32'h0);
      if (i > 0 && cnt - rd == 32'd2) dn = 1'b1;
    end
    chk({31'h0, dn}, 32'h1);
    // clear select 1: compare a sets the period, pin a released
    wr(tpcm_pkg::cmp_a_addr, 32'd20);
    // restart from zero: a count already above the new top would climb to the 11-bit wrap first
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h2, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0));
    wr(tpcm_pkg::ctrl_a_addr, ctl(tpcm_pkg::mode_pwm, 2'h2, 1'b1, 1'b0, 2'h0, 1'b1, 1'b1));
    wr(tpcm_pkg::flags_addr, 32'h7);
    wt(50);
    rdchk(tpcm_pkg::flags_addr, 32'h1, 32'h1);
    chk({31'h0, pa_oe}, 32'h0);
    test_done();
  end
endmodule
